// ### inc/qdw_pkg.sv
/*
  Shared types and constants of the quad DAC two-wire slave.
  Assumes a single system clock domain and an open-drain SDA wire
  resolved outside the design.
*/
package qdw_pkg;

  // Slave address: fixed upper five bits, pins give the low two
  localparam logic [4:0] ADDR_PREFIX = 5'h03;
  localparam int NUM_CHAN = 4;
  localparam int WORD_CODE_W = 12;
  // Bit counter: eight data clocks, ack on the ninth rise
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ACK_DONE = 4'h9;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  // Synchroniser lane positions
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_A0 = 2;
  localparam int SY_A1 = 3;
  localparam int SY_LOAD = 4;
  localparam int SY_PD = 5;
  localparam int SY_W = 6;
  localparam logic [5:0] SYNC_RST = 6'h3F;
  // Reset values
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [11:0] CODE_RST = 12'h000;

  // Pointer byte layout
  typedef struct packed {
    logic [1:0] unused;
    logic justify;  // 0: left-justified
    logic dbl;      // 0: two-byte words
    logic [3:0] sel; // chan_d_select .. chan_a_select
  } qdw_ptr_t;

  // 16-bit data word, first bit on the wire at the top
  typedef struct packed {
    logic gain;
    logic buf_en;
    logic clear_all_n;
    logic power_down_n;
    logic [11:0] code;
  } qdw_word_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_PTR = 3'b010,
    ST_DATA = 3'b011,
    ST_READ = 3'b100
  } qdw_state_t;

endpackage : qdw_pkg

// ### logic/qdw_slave.sv
/*
  Two-wire slave front end of a quad DAC with input and DAC register
  banks per channel. Assumes SCL and SDA are oversampled by CLOCK
  (at least eight times the bus rate) and SDA is resolved externally.
*/
`timescale 1ns/10ps
module qdw_slave #(
  parameter int CODE_W = 12
) (
  input wire logic CLOCK, // System clock, 20 MHz
  input wire logic NRST, // Async reset, active low
  input wire logic SCL, // Bus clock, input only
  input wire logic SDA_IN, // Bus data level
  output logic SDA_OUT, // Data drive value, always low
  output logic SDA_OE, // High while pulling SDA low
  input wire logic ADDR_SELECT_PIN_LOW, // Address bit 0
  input wire logic ADDR_SELECT_PIN_HIGH, // Address bit 1
  input wire logic LOAD_OUTPUTS_N, // DAC register load, active low
  input wire logic POWER_DOWN_N, // Hardware power-down, active low
  output logic [4*CODE_W-1:0] DAC_CODE, // Channel codes, A lowest
  output logic [3:0] CHAN_GAIN, // 1: double output range
  output logic [3:0] CHAN_BUF_EN, // 1: reference buffered
  output logic CHAN_POWERED_DOWN // 1: all outputs high impedance
);

  // Pin synchronisers; only the second stage is read
  logic [qdw_pkg::SY_W-1:0] sync1_ff, sync2_ff;
  logic scl_prev_ff, sda_prev_ff;
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      sync1_ff <= qdw_pkg::SYNC_RST;
      sync2_ff <= qdw_pkg::SYNC_RST;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      sync1_ff <= {POWER_DOWN_N, LOAD_OUTPUTS_N, ADDR_SELECT_PIN_HIGH,
                   ADDR_SELECT_PIN_LOW, SDA_IN, SCL};
      sync2_ff <= sync1_ff;
      scl_prev_ff <= sync2_ff[qdw_pkg::SY_SCL];
      sda_prev_ff <= sync2_ff[qdw_pkg::SY_SDA];
    end
  end

  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  assign scl_s = sync2_ff[qdw_pkg::SY_SCL];
  assign sda_s = sync2_ff[qdw_pkg::SY_SDA];
  assign scl_rise = scl_s && !scl_prev_ff;
  assign scl_fall = !scl_s && scl_prev_ff;
  // Bus conditions: SDA moving while SCL stays high
  assign start_det = scl_s && scl_prev_ff && sda_prev_ff && !sda_s;
  assign stop_det = scl_s && scl_prev_ff && !sda_prev_ff && sda_s;

  qdw_pkg::qdw_state_t st_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff, tx_ff, hi_byte_ff;
  logic oe_ff, rw_ff, byte_idx_ff, mack_ff, pd_bit_ff;
  qdw_pkg::qdw_ptr_t ptr_ff;
  logic commit, addr_match;
  qdw_pkg::qdw_word_t wr_word, rd_word;
  logic [CODE_W-1:0] in_code [qdw_pkg::NUM_CHAN];
  logic [CODE_W-1:0] dac_code [qdw_pkg::NUM_CHAN];
  logic [3:0] in_gain_ff, in_buf_ff;
  // Reset code cut to the configured width
  localparam logic [CODE_W-1:0] CODE_RST_W = CODE_W'(qdw_pkg::CODE_RST);

  assign addr_match = shift_ff[7:1] == {qdw_pkg::ADDR_PREFIX,
      sync2_ff[qdw_pkg::SY_A1], sync2_ff[qdw_pkg::SY_A0]};
  // Word is done once the second data byte's ack clock ends
  assign commit = scl_fall && st_ff == qdw_pkg::ST_DATA &&
      bit_cnt_ff == qdw_pkg::BIT_ACK_DONE && byte_idx_ff;
  assign wr_word = {hi_byte_ff, shift_ff};

  // Readback word: one selected channel, else zero code, gain and buffer fields
  always_comb begin
    rd_word = '0;
    rd_word.clear_all_n = 1'b1;
    rd_word.power_down_n = !pd_bit_ff;
    for (int i = 0; i < qdw_pkg::NUM_CHAN; i++) begin
      if (ptr_ff.sel == 4'(1 << i)) begin
        rd_word.gain = in_gain_ff[i];
        rd_word.buf_en = in_buf_ff[i];
        rd_word.code[qdw_pkg::WORD_CODE_W-1 -: CODE_W] = in_code[i];
      end
    end
  end

  // Byte framing and protocol state; START and STOP override all
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      st_ff <= qdw_pkg::ST_IDLE;
      bit_cnt_ff <= qdw_pkg::BIT_CNT_RST;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      oe_ff <= 1'b0;
      rw_ff <= 1'b0;
      byte_idx_ff <= 1'b0;
      mack_ff <= 1'b0;
      hi_byte_ff <= 8'h00;
    end else if (start_det) begin
      st_ff <= qdw_pkg::ST_ADDR;
      bit_cnt_ff <= qdw_pkg::BIT_CNT_RST;
      oe_ff <= 1'b0;
    end else if (stop_det) begin
      st_ff <= qdw_pkg::ST_IDLE;
      oe_ff <= 1'b0;
    end else if (st_ff != qdw_pkg::ST_IDLE) begin
      if (scl_rise && bit_cnt_ff != qdw_pkg::BIT_ACK_DONE) begin
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
        if (bit_cnt_ff != qdw_pkg::BIT_LAST) begin
          shift_ff <= {shift_ff[6:0], sda_s};
        end else begin
          mack_ff <= !sda_s; // Master ack while reading
        end
      end else if (scl_fall) begin
        if (bit_cnt_ff == qdw_pkg::BIT_LAST) begin
          // Eighth bit has been clocked in or out
          if (st_ff == qdw_pkg::ST_READ) begin
            oe_ff <= 1'b0;
          end else if (st_ff == qdw_pkg::ST_ADDR && !addr_match) begin
            st_ff <= qdw_pkg::ST_IDLE;
            oe_ff <= 1'b0;
          end else begin
            oe_ff <= 1'b1;
            if (st_ff == qdw_pkg::ST_ADDR) begin
              rw_ff <= shift_ff[0];
            end
            if (st_ff == qdw_pkg::ST_DATA && !byte_idx_ff) begin
              hi_byte_ff <= shift_ff;
            end
          end
        end else if (bit_cnt_ff == qdw_pkg::BIT_ACK_DONE) begin
          bit_cnt_ff <= qdw_pkg::BIT_CNT_RST;
          oe_ff <= 1'b0;
          case (st_ff)
            qdw_pkg::ST_ADDR: begin
              byte_idx_ff <= 1'b0;
              if (rw_ff) begin
                // Bare read uses the stored pointer
                st_ff <= qdw_pkg::ST_READ;
                tx_ff <= rd_word[15:8];
                oe_ff <= !rd_word[15];
                byte_idx_ff <= 1'b1;
              end else begin
                st_ff <= qdw_pkg::ST_PTR;
              end
            end
            qdw_pkg::ST_PTR: begin
              st_ff <= qdw_pkg::ST_DATA;
            end
            qdw_pkg::ST_DATA: begin
              byte_idx_ff <= !byte_idx_ff;
            end
            qdw_pkg::ST_READ: begin
              if (mack_ff) begin
                // Continuous readback repeats the two bytes
                tx_ff <= byte_idx_ff ? rd_word[7:0] : rd_word[15:8];
                oe_ff <= byte_idx_ff ? !rd_word[7] : !rd_word[15];
                byte_idx_ff <= !byte_idx_ff;
              end else begin
                st_ff <= qdw_pkg::ST_IDLE;
              end
            end
            default: begin
              st_ff <= qdw_pkg::ST_IDLE;
            end
          endcase
        end else if (st_ff == qdw_pkg::ST_READ) begin
          // Next bit out; open drain, so drive only zeros
          tx_ff <= {tx_ff[6:0], 1'b0};
          oe_ff <= !tx_ff[6];
        end
      end
    end
  end

  // Pointer store; survives STOP for later bare reads
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ptr_ff <= qdw_pkg::PTR_RST;
    end else if (scl_fall && st_ff == qdw_pkg::ST_PTR &&
                 bit_cnt_ff == qdw_pkg::BIT_LAST) begin
      // Justify and count bits only support the zero setting
      ptr_ff <= shift_ff;
    end
  end

  // Software power-down flag, written with every word
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      pd_bit_ff <= 1'b0;
    end else if (commit) begin
      pd_bit_ff <= !wr_word.power_down_n;
    end
  end

  // Per-channel input and DAC register banks
  for (genvar g = 0; g < qdw_pkg::NUM_CHAN; g++) begin : g_chan
    logic [CODE_W-1:0] in_code_ff, dac_code_ff;
    logic dac_gain_ff, dac_buf_ff, dirty_ff, load_now, chan_wr;
    assign load_now = !sync2_ff[qdw_pkg::SY_LOAD] && dirty_ff;
    assign chan_wr = commit && ptr_ff.sel[g];
    assign in_code[g] = in_code_ff;
    assign dac_code[g] = dac_code_ff;

    // Input register; extra low code bits are dropped
    always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
        in_code_ff <= CODE_RST_W;
        in_gain_ff[g] <= 1'b0;
        in_buf_ff[g] <= 1'b0;
      end else if (commit && !wr_word.clear_all_n) begin
        in_code_ff <= CODE_RST_W;
      end else if (chan_wr) begin
        in_code_ff <= wr_word.code[qdw_pkg::WORD_CODE_W-1 -: CODE_W];
        in_gain_ff[g] <= wr_word.gain;
        in_buf_ff[g] <= wr_word.buf_en;
      end
    end

    // Updated-since-load flag; a new write beats the load clear
    always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
        dirty_ff <= 1'b0;
      end else if (chan_wr) begin
        dirty_ff <= 1'b1;
      end else if (load_now) begin
        dirty_ff <= 1'b0;
      end
    end

    // DAC register transparent while load is low
    always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
        dac_code_ff <= CODE_RST_W;
        dac_gain_ff <= 1'b0;
        dac_buf_ff <= 1'b0;
      end else if (commit && !wr_word.clear_all_n) begin
        dac_code_ff <= CODE_RST_W;
      end else if (load_now) begin
        dac_code_ff <= in_code_ff;
        dac_gain_ff <= in_gain_ff[g];
        dac_buf_ff <= in_buf_ff[g];
      end
    end
    assign DAC_CODE[g*CODE_W +: CODE_W] = dac_code_ff;
    assign CHAN_GAIN[g] = dac_gain_ff;
    assign CHAN_BUF_EN[g] = dac_buf_ff;
  end

  // Bus outputs and combined power-down, all registered
  logic pwr_off_ff, sda_out_ff;
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      pwr_off_ff <= 1'b0;
      sda_out_ff <= 1'b0;
    end else begin
      pwr_off_ff <= pd_bit_ff || !sync2_ff[qdw_pkg::SY_PD];
      sda_out_ff <= 1'b0;
    end
  end
  assign CHAN_POWERED_DOWN = pwr_off_ff;
  assign SDA_OE = oe_ff;
  assign SDA_OUT = sda_out_ff;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  AST_ADDR_ACK: assert property (
    scl_fall && !start_det && !stop_det && st_ff == qdw_pkg::ST_ADDR &&
    bit_cnt_ff == qdw_pkg::BIT_LAST && addr_match |=> oe_ff)
    else $error("Matching address not acknowledged");
  AST_ADDR_MISS: assert property (
    scl_fall && !start_det && !stop_det && st_ff == qdw_pkg::ST_ADDR &&
    bit_cnt_ff == qdw_pkg::BIT_LAST && !addr_match
    |=> st_ff == qdw_pkg::ST_IDLE && !oe_ff)
    else $error("Foreign address not ignored");
  AST_SDA_SCL_LOW: assert property (
    $changed(oe_ff) |-> !$past(scl_s) || $past(start_det || stop_det))
    else $error("SDA drive changed while SCL high");
  AST_READ_RELEASE: assert property (
    scl_fall && !stop_det && !start_det && st_ff == qdw_pkg::ST_READ &&
    bit_cnt_ff == qdw_pkg::BIT_LAST |=> !oe_ff)
    else $error("SDA not released for master ack");
  AST_COMMIT_CODE: assert property (
    commit && ptr_ff.sel[0] && wr_word.clear_all_n
    |=> in_code[0] == $past(wr_word.code[11 -: CODE_W]))
    else $error("Selected input register not written");
  AST_CLEAR: assert property (
    commit && !wr_word.clear_all_n
    |=> in_code[3] == '0 && dac_code[2] == '0)
    else $error("Clear did not zero registers");
  AST_LOAD: assert property (
    !sync2_ff[qdw_pkg::SY_LOAD] && g_chan[1].dirty_ff && !commit
    |=> dac_code[1] == $past(in_code[1]))
    else $error("DAC register not loaded while load low");
  AST_PD_BIT: assert property (
    commit |=> ##1 pwr_off_ff == (!$past(wr_word.power_down_n, 2) ||
    !$past(sync2_ff[qdw_pkg::SY_PD])))
    else $error("Power-down state wrong after word");
  AST_BUF_UNSEL: assert property (
    commit && !ptr_ff.sel[1] |=> $stable(in_buf_ff[1]))
    else $error("Buffer bit hit unselected channel");
  AST_IDLE_QUIET: assert property (
    st_ff == qdw_pkg::ST_IDLE |-> !oe_ff && !sda_out_ff)
    else $error("Slave drove the bus while idle");

endmodule : qdw_slave

// ### bench/qdw_master.sv
/*
  Bus master model that faces the quad DAC two-wire slave.
  Assumes the bench resolves SDA from both pull-down enables,
  with a pull-up, and calls these tasks from one process.
*/
`timescale 1ns/10ps
module qdw_master (
  input wire logic clk, // Bench system clock
  input wire logic sda, // Resolved data wire
  output logic scl, // Bus clock, high while idle
  output logic sda_low // 1: pull data wire low
);
  // Bus idle: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Quarter bus period is two system clocks, bus period 400 ns
  task automatic q(input int n);
    repeat (2 * n) @(posedge clk);
  endtask : q

  // Also serves as repeated start: release data before clock rises
  task automatic start();
    sda_low <= 1'b0;
    q(1);
    scl <= 1'b1;
    q(1);
    sda_low <= 1'b1;
    q(1);
    scl <= 1'b0;
    q(1);
  endtask : start

  // Data moves only in the low half, sampled mid high half
  task automatic bit_x(input logic b, output logic r);
    sda_low <= !b;
    q(1);
    scl <= 1'b1;
    q(1);
    r = sda;
    q(1);
    scl <= 1'b0;
    q(1);
  endtask : bit_x

  // Eight bits MSB first, then the slave's acknowledge
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask : wr

  // Last byte of a read is refused so the slave lets go
  task automatic rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask : rd

  // Data low before the tenth pulse, released while clock high
  task automatic stop();
    sda_low <= 1'b1;
    q(1);
    scl <= 1'b1;
    q(1);
    sda_low <= 1'b0;
    q(2);
  endtask : stop
endmodule : qdw_master

// ### bench/testbench.sv
/*
  Self-checking bench of the quad DAC two-wire slave.
  Assumes the bus master model in bench/ and the slave at its
  default 12-bit code width.
*/
`timescale 1ns/10ps
module testbench;
  logic [1:0] pins;
  wire [6:0] own = {qdw_pkg::ADDR_PREFIX, pins};
  logic clk, nrst, ld_n, pd_n, scl, m_low, sda_oe, sda_out, pdn_out, a;
  logic [15:0] rw;
  logic [47:0] code;
  logic [3:0] gain, buff;
  int error_cnt = 0;
  int num_checks = 0;
  // Open-drain wire with pull-up, either party may pull low
  wire sda = !(m_low || (sda_oe && !sda_out));

  qdw_slave #(.CODE_W(12)) u_qdw_slave (
    .CLOCK(clk), .NRST(nrst), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .ADDR_SELECT_PIN_LOW(pins[0]), .ADDR_SELECT_PIN_HIGH(pins[1]),
    .LOAD_OUTPUTS_N(ld_n), .POWER_DOWN_N(pd_n), .DAC_CODE(code),
    .CHAN_GAIN(gain), .CHAN_BUF_EN(buff), .CHAN_POWERED_DOWN(pdn_out)
  );
  qdw_master u_qdw_master (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));

  always #25 clk = ~clk;

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // Write: address, pointer, then nb data bytes; nb=1 cuts the word
  task automatic send(input logic [7:0] ptr, input logic [15:0] w,
                      input int nb);
    logic k;
    u_qdw_master.start();
    u_qdw_master.wr({own, 1'b0}, k);
    chk(k, 1'b1);
    u_qdw_master.wr(ptr, k);
    chk(k, 1'b1);
    for (int i = 0; i < nb; i++) begin
      u_qdw_master.wr(w[15 - 8 * i -: 8], k);
      chk(k, 1'b1);
    end
    u_qdw_master.stop();
    repeat (4) @(posedge clk);
  endtask : send

  // Read one word, optionally loading the pointer first
  task automatic fetch(input logic with_ptr, input logic [7:0] ptr,
                       input logic [15:0] exp);
    logic k;
    logic [15:0] w;
    u_qdw_master.start();
    if (with_ptr) begin
      u_qdw_master.wr({own, 1'b0}, k);
      u_qdw_master.wr(ptr, k);
      u_qdw_master.start();
    end
    u_qdw_master.wr({own, 1'b1}, k);
    chk(k, 1'b1);
    u_qdw_master.rd(1'b0, w[15:8]);
    u_qdw_master.rd(1'b1, w[7:0]);
    u_qdw_master.stop();
    chk(w, exp);
  endtask : fetch

  // Main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    ld_n = 1'b0;
    pd_n = 1'b1;
    pins = 2'b10;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    chk(code, 48'h0);
    chk({gain, buff, pdn_out}, 9'h000);
    fetch(1'b0, 8'h00, 16'h3000);
    // Foreign address: neither address nor next byte is acked
    u_qdw_master.start();
    u_qdw_master.wr({qdw_pkg::ADDR_PREFIX, ~pins, 1'b0}, a);
    chk(a, 1'b0);
    u_qdw_master.wr(8'h01, a);
    chk(a, 1'b0);
    u_qdw_master.stop();
    send(8'h01, 16'hFABC, 2);
    chk(code, 48'h000000000ABC);
    chk({gain, buff}, 8'h11);
    // Hold DAC registers, then write B and C together
    ld_n <= 1'b1;
    send(8'h06, 16'h3123, 2);
    chk(code, 48'h000000000ABC);
    ld_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk(code, 48'h000123123ABC);
    chk({gain, buff}, 8'h11);
    fetch(1'b1, 8'h02, 16'h3123);
    fetch(1'b0, 8'h00, 16'h3123);
    fetch(1'b1, 8'h06, 16'h3000);
    // Word cut after its first byte changes no channel register
    send(8'h01, 16'h3FFF, 1);
    chk(code, 48'h000123123ABC);
    fetch(1'b1, 8'h01, 16'hFABC);
    // Acked readback keeps repeating the same word
    u_qdw_master.start();
    u_qdw_master.wr({own, 1'b1}, a);
    chk(a, 1'b1);
    for (int i = 0; i < 3; i++) begin
      u_qdw_master.rd(1'b0, rw[15:8]);
      u_qdw_master.rd(i == 2, rw[7:0]);
      chk(rw, 16'hFABC);
    end
    u_qdw_master.stop();
    send(8'h08, 16'h2000, 2);
    chk(pdn_out, 1'b1);
    send(8'h08, 16'h3000, 2);
    chk(pdn_out, 1'b0);
    pd_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk(pdn_out, 1'b1);
    pd_n <= 1'b1;
    // Clear word zeroes every code register
    send(8'h08, 16'h1000, 2);
    chk(code, 48'h0);
    chk({gain, buff}, 8'h11);
    // New pin levels move the slave address with them
    pins <= 2'b01;
    repeat (4) @(posedge clk);
    fetch(1'b1, 8'h01, 16'hF000);
    // Mid-run reset restores power-on state and pointer
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    chk(code, 48'h0);
    chk({gain, buff, pdn_out}, 9'h000);
    fetch(1'b0, 8'h00, 16'h3000);
    test_done();
  end

  // Run needs about 4700 cycles; a hang is cut well beyond that
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule : testbench
